// ---- shm_pkg.sv ----
// Shared constants and types for the sensor host mailbox and status registers.
// Assumes a register front end and a sequencer on the same clk_sys.
package shm_pkg;

	// Register offsets
	localparam logic [7:0] SHM_ADDR_PARAMETER_WRITE_MAILBOX = 8'h17;
	localparam logic [7:0] SHM_ADDR_CMD      = 8'h18;
	localparam logic [7:0] SHM_ADDR_RESP     = 8'h20;
	localparam logic [7:0] SHM_ADDR_FLAGS    = 8'h21;
	localparam logic [7:0] SHM_ADDR_VIS_LO   = 8'h22;
	localparam logic [7:0] SHM_ADDR_VIS_HI   = 8'h23;
	localparam logic [7:0] SHM_ADDR_IR_LO    = 8'h24;
	localparam logic [7:0] SHM_ADDR_IR_HI    = 8'h25;
	localparam logic [7:0] SHM_ADDR_PS1_LO   = 8'h26;
	localparam logic [7:0] SHM_ADDR_PS1_HI   = 8'h27;

	// Reset values
	localparam logic [7:0]  SHM_RST_BYTE   = 8'h00;
	localparam logic [15:0] SHM_RST_RESULT = 16'h0000;
	localparam logic [5:0]  SHM_RST_FLAGS  = 6'h00;

	// Command codes for recovery (plain defaults)
	localparam logic [7:0] SHM_CMD_NOP   = 8'h00;
	localparam logic [7:0] SHM_CMD_RESET = 8'h01;

	// Response codes
	localparam logic [7:0] SHM_ERR_MSB     = 8'h80;
	localparam logic [7:0] SHM_ERR_INVALID = 8'h80;
	localparam logic [7:0] SHM_ERR_PS1     = 8'h88;
	localparam logic [7:0] SHM_ERR_PS2     = 8'h89;
	localparam logic [7:0] SHM_ERR_PS3     = 8'h8A;
	localparam logic [7:0] SHM_ERR_VIS     = 8'h8C;
	localparam logic [7:0] SHM_ERR_IR_A    = 8'h8D;
	localparam logic [7:0] SHM_ERR_IR_B    = 8'h8E;
	localparam logic [3:0] SHM_CNT_ONE     = 4'h1;
	localparam int         SHM_ERR_BIT     = 7;

	// Flag field positions
	localparam int SHM_FLAG_CMD  = 5;
	localparam int SHM_FLAG_PS3  = 4;
	localparam int SHM_FLAG_PS2  = 3;
	localparam int SHM_FLAG_PS1  = 2;
	localparam int SHM_FLAG_ALSH = 1;
	localparam int SHM_FLAG_ALSL = 0;
	localparam int SHM_NFLAGS    = 6;

	// Alert method that keeps a proximity flag in auto-clear mode
	localparam logic [1:0] SHM_IM_KEEP = 2'b11;

	// Measurement channel
	typedef enum logic [2:0] {
		SHM_CH_PS1,
		SHM_CH_PS2,
		SHM_CH_PS3,
		SHM_CH_VIS,
		SHM_CH_IR_A,
		SHM_CH_IR_B
	} shm_chan_t;

	// Host register access
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} shm_bus_t;

	// Command handed to the sequencer
	typedef struct packed {
		logic [7:0] code;
		logic [7:0] param;
	} shm_cmd_t;

	// Measurement report from the sequencer
	typedef struct packed {
		logic      valid;
		logic      overflow;
		shm_chan_t chan;
		logic [15:0] value;
	} shm_meas_t;

endpackage

// ---- shm_regs.sv ----
// Host-visible mailbox, response, event flag and result registers.
// Assumes the serial front end and the sequencer run on clk_sys.
//
// Behaviour
// - A host write to the command mailbox is the one bus access that wakes the chip.
// - The command mailbox passes each accepted host command on to the sequencer.
// - An error met while processing a command loads an error code into the response.
// - Every error code in the response has its top bit set.
// - A held error stays until rst, a reset or no-operation command, or a host write to the response register.
// - While an error is held only reset and no-operation commands are accepted.
// - A held error does not stop autonomous measurements or their result updates.
// - Without error the response is 0x00 to 0x0F, its low nibble a wrapping counter.
// - An unrecognised command reports the invalid-command code.
// - Converter overflow on proximity one, two or three loads its own code.
// - Overflow on visible ambient and on infrared ambient loads their own codes.
// - Flags sit at bits 5 to 0 and the interrupt asserts on any enabled set flag.
// - In interrupt mode 0 a flag clears only when the host writes a one to it.
// - In interrupt mode 1 the sequencer clears flags except proximity with method 11.
// - A parameter-write mailbox carries a value to go with each command.
`timescale 1ns/1ps

module shm_regs
	import shm_pkg::*;
(
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	input  wire shm_bus_t              bus_in,
	output logic      [7:0]            rd_data_q,
	output logic                       rd_valid_q,
	output logic                       wake_q,
	output logic                       cmd_valid_q,
	output shm_cmd_t                   cmd_q,
	input  wire logic                  seq_done,
	input  wire logic                  seq_invalid,
	input  wire shm_meas_t             meas_in,
	input  wire logic [SHM_NFLAGS-1:0] flag_set,
	input  wire logic [SHM_NFLAGS-1:0] flag_enable,
	input  wire logic                  int_mode,
	input  wire logic                  seq_auto_clear,
	input  wire logic [1:0]            ps1_alert_method,
	input  wire logic [1:0]            ps2_alert_method,
	input  wire logic [1:0]            ps3_alert_method,
	output logic                       irq_q
);

	// Overflow code for each channel
	function automatic logic [7:0] shm_ovf_code(input shm_chan_t ch);
		case (ch)
			SHM_CH_PS1:  shm_ovf_code = SHM_ERR_PS1;
			SHM_CH_PS2:  shm_ovf_code = SHM_ERR_PS2;
			SHM_CH_PS3:  shm_ovf_code = SHM_ERR_PS3;
			SHM_CH_VIS:  shm_ovf_code = SHM_ERR_VIS;
			SHM_CH_IR_A: shm_ovf_code = SHM_ERR_IR_A;
			SHM_CH_IR_B: shm_ovf_code = SHM_ERR_IR_B;
			default:     shm_ovf_code = SHM_ERR_INVALID;
		endcase
	endfunction

	// Address match with write strobe
	function automatic logic shm_hit(input shm_bus_t b, input logic [7:0] a);
		shm_hit = b.wr && (b.addr == a);
	endfunction

	logic [7:0]            param_q;
	logic [7:0]            resp_q;
	logic [SHM_NFLAGS-1:0] flags_q;
	logic [SHM_NFLAGS-1:0] flags_d;
	logic [SHM_NFLAGS-1:0] auto_mask;
	logic [15:0]           vis_q;
	logic [15:0]           ir_q;
	logic [15:0]           ps1_q;
	logic                  err_held;
	logic                  cmd_wr;
	logic                  cmd_recover;
	logic                  cmd_accept;
	logic [7:0]            rd_mux;

	// Command strobe decode
	assign err_held    = resp_q[SHM_ERR_BIT];
	assign cmd_wr      = shm_hit(bus_in, SHM_ADDR_CMD);
	assign cmd_recover = (bus_in.wdata == SHM_CMD_NOP) || (bus_in.wdata == SHM_CMD_RESET);
	assign cmd_accept  = cmd_wr && (!err_held || cmd_recover);

	// Parameter mailbox
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			param_q <= SHM_RST_BYTE;
		end else if (shm_hit(bus_in, SHM_ADDR_PARAMETER_WRITE_MAILBOX)) begin
			param_q <= bus_in.wdata;
		end
	end

	// Wake pulse on any command write, even one later ignored
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= cmd_wr;
		end
	end

	// Hand accepted commands to the sequencer
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cmd_valid_q <= 1'b0;
			cmd_q       <= '0;
		end else begin
			cmd_valid_q <= cmd_accept;
			if (cmd_accept) begin
				cmd_q.code  <= bus_in.wdata;
				cmd_q.param <= param_q;
			end
		end
	end

	// Response register: errors, recovery and completion counter
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			resp_q <= SHM_RST_BYTE;
		end else if (meas_in.valid && meas_in.overflow && !err_held) begin
			resp_q <= shm_ovf_code(meas_in.chan);
		end else if (seq_done && seq_invalid && !err_held) begin
			resp_q <= SHM_ERR_INVALID;
		end else if (cmd_accept && cmd_recover) begin
			resp_q <= SHM_RST_BYTE;
		end else if (seq_done && !seq_invalid && !err_held) begin
			resp_q <= {4'h0, resp_q[3:0] + SHM_CNT_ONE};
		end else if (shm_hit(bus_in, SHM_ADDR_RESP)) begin
			resp_q <= bus_in.wdata;
		end
	end

	// Flags that the sequencer may clear in mode 1
	always_comb begin
		auto_mask                = '1;
		auto_mask[SHM_FLAG_PS1]  = (ps1_alert_method != SHM_IM_KEEP);
		auto_mask[SHM_FLAG_PS2]  = (ps2_alert_method != SHM_IM_KEEP);
		auto_mask[SHM_FLAG_PS3]  = (ps3_alert_method != SHM_IM_KEEP);
	end

	// Flag next state; a new event wins over any clear
	always_comb begin
		flags_d = flags_q;
		if (shm_hit(bus_in, SHM_ADDR_FLAGS)) begin
			flags_d = flags_d & ~bus_in.wdata[SHM_NFLAGS-1:0];
		end
		if (int_mode && seq_auto_clear) begin
			flags_d = flags_d & ~auto_mask;
		end
		flags_d = flags_d | flag_set;
	end

	// Flag register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flags_q <= SHM_RST_FLAGS;
		end else begin
			flags_q <= flags_d;
		end
	end

	// Interrupt level from enabled flags
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(flags_d & flag_enable);
		end
	end

	// Result registers; updates go on regardless of a held error
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			vis_q <= SHM_RST_RESULT;
			ir_q  <= SHM_RST_RESULT;
			ps1_q <= SHM_RST_RESULT;
		end else begin
			if (shm_hit(bus_in, SHM_ADDR_VIS_LO)) vis_q[7:0]  <= bus_in.wdata;
			if (shm_hit(bus_in, SHM_ADDR_VIS_HI)) vis_q[15:8] <= bus_in.wdata;
			if (shm_hit(bus_in, SHM_ADDR_IR_LO))  ir_q[7:0]   <= bus_in.wdata;
			if (shm_hit(bus_in, SHM_ADDR_IR_HI))  ir_q[15:8]  <= bus_in.wdata;
			if (shm_hit(bus_in, SHM_ADDR_PS1_LO)) ps1_q[7:0]  <= bus_in.wdata;
			if (shm_hit(bus_in, SHM_ADDR_PS1_HI)) ps1_q[15:8] <= bus_in.wdata;
			if (meas_in.valid && !meas_in.overflow) begin
				case (meas_in.chan)
					SHM_CH_VIS: begin
						vis_q <= meas_in.value;
					end
					SHM_CH_IR_A, SHM_CH_IR_B: begin
						ir_q <= meas_in.value;
					end
					SHM_CH_PS1: begin
						ps1_q <= meas_in.value;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Read data selection, unmapped reads as zero
	always_comb begin
		case (bus_in.addr)
			SHM_ADDR_PARAMETER_WRITE_MAILBOX: rd_mux = param_q;
			SHM_ADDR_CMD:      rd_mux = cmd_q.code;
			SHM_ADDR_RESP:     rd_mux = resp_q;
			SHM_ADDR_FLAGS:    rd_mux = {2'b00, flags_q};
			SHM_ADDR_VIS_LO:   rd_mux = vis_q[7:0];
			SHM_ADDR_VIS_HI:   rd_mux = vis_q[15:8];
			SHM_ADDR_IR_LO:    rd_mux = ir_q[7:0];
			SHM_ADDR_IR_HI:    rd_mux = ir_q[15:8];
			SHM_ADDR_PS1_LO:   rd_mux = ps1_q[7:0];
			SHM_ADDR_PS1_HI:   rd_mux = ps1_q[15:8];
			default:           rd_mux = SHM_RST_BYTE;
		endcase
	end

	// Registered read answer
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_data_q  <= SHM_RST_BYTE;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= bus_in.rd;
			if (bus_in.rd) begin
				rd_data_q <= rd_mux;
			end
		end
	end

endmodule

// ---- shm_regs_assertions.sv ----
// Port-level checker for the mailbox and status registers.
// Assumes one clk_sys domain and rst active high.
`timescale 1ns/1ps

module shm_regs_assertions
	import shm_pkg::*;
(
	input wire logic                  clk_sys,
	input wire logic                  rst,
	input wire shm_bus_t              bus_in,
	input wire logic                  wake_q,
	input wire logic                  cmd_valid_q,
	input wire shm_cmd_t              cmd_q,
	input wire logic [SHM_NFLAGS-1:0] flag_set,
	input wire logic [SHM_NFLAGS-1:0] flag_enable,
	input wire logic                  int_mode,
	input wire logic                  seq_auto_clear,
	input wire logic [1:0]            ps1_alert_method,
	input wire logic [1:0]            ps2_alert_method,
	input wire logic [1:0]            ps3_alert_method,
	input wire logic                  irq_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	wake_on_cmd_a:
		assert property (bus_in.wr && bus_in.addr == SHM_ADDR_CMD |=> wake_q)
		else $error("No wake after command write");
	wake_only_cmd_a:
		assert property (!(bus_in.wr && bus_in.addr == SHM_ADDR_CMD) |=> !wake_q)
		else $error("Wake without command write");
	cmd_passed_a:
		assert property (cmd_valid_q |-> wake_q && cmd_q.code == $past(bus_in.wdata))
		else $error("Command not passed on");
	cmd_held_a:
		assert property (!cmd_valid_q |-> $stable(cmd_q))
		else $error("Command changed without acceptance");
	irq_raise_a:
		assert property (|(flag_set & flag_enable) |=> irq_q)
		else $error("Enabled flag did not raise interrupt");
	irq_mask_a:
		assert property (flag_enable == '0 |=> !irq_q)
		else $error("Interrupt with no enables");
	irq_hold_a:
		assert property (!int_mode && irq_q && !bus_in.wr && $stable(flag_enable) |=> irq_q)
		else $error("Flag lost in host-clear mode");
	irq_auto_a:
		assert property (int_mode && seq_auto_clear && flag_set == '0
			&& ps1_alert_method != SHM_IM_KEEP && ps2_alert_method != SHM_IM_KEEP
			&& ps3_alert_method != SHM_IM_KEEP |=> !irq_q)
		else $error("Auto clear left interrupt high");

	cover property (cmd_valid_q);
	cover property (int_mode && seq_auto_clear);
	cover property (irq_q && !int_mode ##1 !irq_q);
endmodule

// ---- shm_host.sv ----
// Host register master model for the mailbox block.
// Assumes accesses start 1 ns after a rising edge of clk_sys.
`timescale 1ns/1ps

module shm_host
	import shm_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic [7:0] rd_data_q,
	output shm_bus_t        bus
);
	initial bus = '0;

	// Write strobe for commands, recovery, parameters, flag clears
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys) #1;
		bus = '{1'b1, 1'b0, a, d};
		@(posedge clk_sys) #1;
		bus = '{1'b0, 1'b0, ~a, ~d}; // Released lines toggle away
	endtask

	// Read strobe; data stands after the taking edge
	task automatic get(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys) #1;
		bus = '{1'b0, 1'b1, a, 8'hA5};
		@(posedge clk_sys) #1;
		bus = '{1'b0, 1'b0, ~a, 8'h5A};
		d = rd_data_q;
	endtask
endmodule

// ---- shm_regs_test.sv ----
// Self-checking bench for the mailbox, response, flag and result registers.
// Assumes shm_host plays the host; the bench plays the sequencer.
`timescale 1ns/1ps

module shm_regs_test import shm_pkg::*;;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	shm_bus_t    bus_in;
	shm_cmd_t    cmd_q;
	shm_meas_t   meas_in, m;
	logic [7:0]  rd_data_q, p, c, w;
	logic        rd_valid_q, wake_q, cmd_valid_q, irq_q, int_mode, seq_auto_clear;
	logic        seq_done, seq_invalid;
	logic [5:0]  flag_set, flag_enable, fs;
	logic [1:0]  ps1_alert_method, ps2_alert_method, ps3_alert_method;
	logic [15:0] v;
	int          mismatches = 0, n_tests = 0, cycles = 0, seed, i, k;
	logic [7:0]  codes [6] = '{SHM_ERR_PS1, SHM_ERR_PS2, SHM_ERR_PS3,
		SHM_ERR_VIS, SHM_ERR_IR_A, SHM_ERR_IR_B};

	always #5 clk_sys = ~clk_sys;
	shm_host i_shm_host (.clk_sys(clk_sys), .rd_data_q(rd_data_q), .bus(bus_in));
	shm_regs i_shm_regs (.*);

	// Flags that survive a sequencer auto clear
	function automatic logic [7:0] left(input logic [5:0] f);
		return {2'b00, f & {1'b0, ps3_alert_method == SHM_IM_KEEP,
			ps2_alert_method == SHM_IM_KEEP, ps1_alert_method == SHM_IM_KEEP, 2'b00}};
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		i_shm_host.get(a, d);
		check(d, exp);
		check(rd_valid_q, 1'b1);
	endtask

	// One-cycle sequencer pulses
	task automatic fire(input logic dn, input logic iv, input shm_meas_t mm,
		input logic [5:0] f, input logic ac);
		@(posedge clk_sys) #1;
		{seq_done, seq_invalid, meas_in, flag_set, seq_auto_clear} = {dn, iv, mm, f, ac};
		@(posedge clk_sys) #1;
		{seq_done, seq_invalid, meas_in, flag_set, seq_auto_clear} = '0;
	endtask

	task automatic give_verdict;
		if (mismatches == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Cut a hang short
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			give_verdict;
		end
	end

	initial begin
		seed = 32'h96FD8DBB;
		{seq_done, seq_invalid, meas_in, flag_set, seq_auto_clear} = '0;
		{flag_enable, int_mode, ps1_alert_method, ps2_alert_method, ps3_alert_method} = '0;
		repeat (5) @(posedge clk_sys);
		#1 rst = 1'b0;
		rdc(SHM_ADDR_FLAGS, SHM_RST_BYTE);
		rdc(SHM_ADDR_RESP, SHM_RST_BYTE);
		rdc(8'h30, 8'h00);
		// Parameter and command reach the sequencer together
		p = 8'($random(seed));
		c = 8'h02 | (8'($random(seed)) & 8'h3C);
		i_shm_host.put(SHM_ADDR_PARAMETER_WRITE_MAILBOX, p);
		i_shm_host.put(SHM_ADDR_CMD, c);
		check({wake_q, cmd_valid_q}, 2'b11);
		check(cmd_q, {c, p});
		rdc(SHM_ADDR_CMD, c);
		// Completion counter wraps past 0xF
		for (i = 1; i <= 17; i++) begin
			fire(1'b1, 1'b0, '0, '0, 1'b0);
			rdc(SHM_ADDR_RESP, {4'h0, 4'(i)});
		end
		// Held error refuses commands, not measurements
		fire(1'b1, 1'b1, '0, '0, 1'b0);
		rdc(SHM_ADDR_RESP, SHM_ERR_INVALID);
		i_shm_host.put(SHM_ADDR_CMD, c);
		check({wake_q, cmd_valid_q}, 2'b10);
		v = 16'($random(seed));
		m = '{1'b1, 1'b0, SHM_CH_PS1, v};
		fire(1'b1, 1'b0, m, '0, 1'b0);
		rdc(SHM_ADDR_RESP, SHM_ERR_INVALID);
		rdc(SHM_ADDR_PS1_HI, v[15:8]);
		i_shm_host.put(SHM_ADDR_CMD, SHM_CMD_NOP);
		check(cmd_valid_q, 1'b1);
		rdc(SHM_ADDR_RESP, 8'h00);
		// Each overflow loads its own code
		for (k = 0; k < 6; k++) begin
			m = '{1'b1, 1'b1, shm_chan_t'(k), 16'($random(seed))};
			fire(1'b0, 1'b0, m, '0, 1'b0);
			rdc(SHM_ADDR_RESP, codes[k]);
			i_shm_host.put(SHM_ADDR_CMD, SHM_CMD_RESET);
			rdc(SHM_ADDR_RESP, 8'h00);
		end
		// Results in low and high bytes
		for (k = 0; k < 3; k++) begin
			v = 16'($random(seed));
			m = '{1'b1, 1'b0, (k == 2) ? SHM_CH_PS1 : shm_chan_t'(k + 3), v};
			fire(1'b0, 1'b0, m, '0, 1'b0);
			rdc(SHM_ADDR_VIS_LO + 8'(2 * k), v[7:0]);
			rdc(SHM_ADDR_VIS_HI + 8'(2 * k), v[15:8]);
		end
		// Host-cleared flags and the interrupt line
		fs = 6'($random(seed)) | 6'h20;
		flag_enable = 6'($random(seed));
		fire(1'b0, 1'b0, '0, fs, 1'b1);
		rdc(SHM_ADDR_FLAGS, {2'b00, fs});
		check(irq_q, |(fs & flag_enable));
		w = 8'($random(seed)) & {2'b00, fs};
		i_shm_host.put(SHM_ADDR_FLAGS, w);
		rdc(SHM_ADDR_FLAGS, {2'b00, fs} & ~w);
		i_shm_host.put(SHM_ADDR_FLAGS, 8'h3F);
		// Sequencer auto clear keeps method-11 proximity flags
		int_mode = 1'b1;
		for (k = 0; k < 4; k++) begin
			{ps1_alert_method, ps2_alert_method, ps3_alert_method} =
				(k == 0) ? 6'h00 : 6'($random(seed));
			fire(1'b0, 1'b0, '0, 6'h3F, 1'b0);
			fire(1'b0, 1'b0, '0, '0, 1'b1);
			rdc(SHM_ADDR_FLAGS, left(6'h3F));
			i_shm_host.put(SHM_ADDR_FLAGS, 8'h3F);
		end
		give_verdict;
	end
endmodule

bind shm_regs shm_regs_assertions i_shm_regs_assertions (.*);
